// ==== src/dbw_ctrl.sv ====
// Double-buffered output code controller with watchdog clear.
`timescale 1ns/100ps
`default_nettype none
module dbw_ctrl #(
  parameter int CHANNELS = 8,
  parameter logic [9:0] BASE = 10'h390,
  parameter int SHORT_CYC = dbw_pkg::WD_SHORT_CYC,
  parameter int MID_CYC = dbw_pkg::WD_MID_CYC,
  parameter int LONG_CYC = dbw_pkg::WD_LONG_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire dbw_pkg::dbw_io_s io,
  input wire logic clear_n,
  input wire logic [dbw_pkg::MAX_CH/2-1:0] bipolar_sel,
  input wire logic wd_enable,
  input wire logic [1:0] wd_sel,
  output logic [CHANNELS*dbw_pkg::CODE_W-1:0] out_codes,
  output logic latch_strobe,
  output logic wd_clear
);
  import dbw_pkg::*;
  localparam int PAIRS = CHANNELS / 2;
  // Only whole pairs are served; an odd count would split a converter.
  if (CHANNELS != 8 && CHANNELS != 6 && CHANNELS != 4)
  begin : g_bad_channels
    $error("CHANNELS must be 8, 6 or 4.");
  end
  // The channel window must fit the address space, or decoding would wrap.
  if (int'(BASE) + 2 * CHANNELS > (1 << ADDR_W))
  begin : g_bad_base
    $error("BASE leaves no room for all channels.");
  end

  // Pin-level inputs pass two flip-flops before use.
  dbw_io_s io_s1_r, io_s2_r;
  logic [1:0] clr_sync_r;
  logic [MAX_CH/2-1:0] bip_s1_r, bip_s2_r;
  logic en_s1_r, en_s2_r;
  logic [1:0] sel_s1_r, sel_s2_r;
  logic rd_d_r, wr_d_r;
  // The host holds address and data for several cycles around its strobe,
  // so the whole bus word is synchronised as one; a shorter hold would tear it.
  always_ff @(posedge mclk)
  begin
    io_s1_r <= io;
    io_s2_r <= io_s1_r;
  end

  // Inverted on entry so that a set bit means a clear is requested.
  always_ff @(posedge mclk)
  begin
    clr_sync_r <= {clr_sync_r[0], ~clear_n};
  end

  always_ff @(posedge mclk)
  begin
    bip_s1_r <= bipolar_sel;
    bip_s2_r <= bip_s1_r;
  end

  // The watchdog settings are static, so skew between their bits is harmless.
  always_ff @(posedge mclk)
  begin
    en_s1_r <= wd_enable;
    en_s2_r <= en_s1_r;
    sel_s1_r <= wd_sel;
    sel_s2_r <= sel_s1_r;
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
    end
    else
    begin
      rd_d_r <= io_s2_r.rd;
      wr_d_r <= io_s2_r.wr;
    end
  end

  function automatic logic in_window(input logic [9:0] a);
    return (a >= BASE) && (a < BASE + 10'(2 * CHANNELS));
  endfunction

  function automatic logic [11:0] zero_of(input logic bip);
    return bip ? ZERO_BIPOLAR : ZERO_UNIPOLAR;
  endfunction

  // Strobe and write events are taken once per host cycle, on the leading edge.
  logic rd_rise, wr_rise, strobe, kick;
  logic [9:0] offs;
  assign rd_rise = io_s2_r.rd && !rd_d_r;
  assign wr_rise = io_s2_r.wr && !wr_d_r;
  assign strobe = rd_rise && (io_s2_r.addr == BASE);
  assign offs = io_s2_r.addr - BASE;
  assign kick = wr_rise && in_window(io_s2_r.addr);

  // Clear is asserted by the clear pin or watchdog expiry and acts on every channel at once.
  logic wd_expire, clear_any;
  assign clear_any = clr_sync_r[1] || wd_clear;

  dbw_watchdog #(
    .SHORT_CYC(SHORT_CYC),
    .MID_CYC(MID_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_wd (
    .mclk(mclk),
    .srst(srst),
    .enable(en_s2_r),
    .sel(sel_s2_r),
    .kick(kick),
    .expire(wd_expire)
  );

  logic [CODE_W-1:0] in_r [CHANNELS];
  logic [CODE_W-1:0] lat_r [CHANNELS];

  // Input registers: write-only halves, accepted in either order.
  always_ff @(posedge mclk)
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (srst || clear_any)
      begin
        in_r[c] <= zero_of(bip_s2_r[c/2]);
      end
      else if (kick && offs[9:1] == 9'(c))
      begin
        if (!offs[0])
        begin
          in_r[c][LOW_W-1:0] <= io_s2_r.data;
        end
        else
        begin
          in_r[c][CODE_W-1:LOW_W] <= io_s2_r.data[HIGH_W-1:0];
        end
      end
    end
  end

  // Latches change only on the strobe, a clear or reset, both channels of every pair together.
  always_ff @(posedge mclk)
  begin
    for (int p = 0; p < PAIRS; p++)
    begin
      if (srst || clear_any)
      begin
        lat_r[2*p] <= zero_of(bip_s2_r[p]);
        lat_r[2*p+1] <= zero_of(bip_s2_r[p]);
      end
      else if (strobe)
      begin
        lat_r[2*p] <= in_r[2*p];
        lat_r[2*p+1] <= in_r[2*p+1];
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      out_codes[c*CODE_W +: CODE_W] = lat_r[c];
    end
  end

  // A strobe that meets a clear is dropped, so a late latch never undoes a clear.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      latch_strobe <= 1'b0;
    end
    else
    begin
      latch_strobe <= strobe && !clear_any;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wd_clear <= 1'b0;
    end
    else
    begin
      wd_clear <= wd_expire;
    end
  end
endmodule : dbw_ctrl
`default_nettype wire

// ==== src/dbw_pkg.sv ====
// Package of constants and carrier types for the double-buffered output controller.
package dbw_pkg;
  localparam int CODE_W = 12;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 4;
  localparam int ADDR_W = 10;
  localparam int MAX_CH = 8;
  localparam logic [11:0] ZERO_UNIPOLAR = 12'h000;
  localparam logic [11:0] ZERO_BIPOLAR = 12'h800;
  localparam int CLK_HZ = 40000000;
  localparam int WD_SHORT_MS = 5;
  localparam int WD_MID_MS = 500;
  localparam int WD_LONG_MS = 5000;
  localparam int WD_SHORT_CYC = CLK_HZ / 1000 * WD_SHORT_MS;
  localparam int WD_MID_CYC = CLK_HZ / 1000 * WD_MID_MS;
  localparam int WD_LONG_CYC = CLK_HZ / 1000 * WD_LONG_MS;
  localparam logic [1:0] WD_SEL_SHORT = 2'h0;
  localparam logic [1:0] WD_SEL_MID = 2'h1;
  localparam logic [1:0] WD_SEL_LONG = 2'h2;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] data;
  } dbw_io_s;
endpackage : dbw_pkg

// ==== src/dbw_watchdog.sv ====
// Watchdog timer that requests a clear when no channel write arrives in time.
`timescale 1ns/100ps
`default_nettype none
module dbw_watchdog #(
  parameter int SHORT_CYC = dbw_pkg::WD_SHORT_CYC,
  parameter int MID_CYC = dbw_pkg::WD_MID_CYC,
  parameter int LONG_CYC = dbw_pkg::WD_LONG_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic enable,
  input wire logic [1:0] sel,
  input wire logic kick,
  output logic expire
);
  import dbw_pkg::*;
  logic [31:0] cnt_r;
  logic [31:0] limit;
  logic en_d_r;
  // A zero interval would fire the clear on every other cycle.
  if (SHORT_CYC < 1 || MID_CYC < 1 || LONG_CYC < 1)
  begin : g_bad_interval
    $error("Watchdog intervals must be at least one cycle.");
  end
  always_comb
  begin
    case (sel)
      WD_SEL_SHORT: limit = 32'(SHORT_CYC);
      WD_SEL_MID: limit = 32'(MID_CYC);
      default: limit = 32'(LONG_CYC);
    endcase
  end
  // A kick restarts the interval; enabling and expiry restart from zero.
  always_ff @(posedge mclk)
  begin
    if (srst || !enable || kick || expire || !en_d_r)
    begin
      cnt_r <= 32'h0;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      en_d_r <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      en_d_r <= enable;
      expire <= enable && en_d_r && !kick && !expire && (cnt_r + 32'h1 >= limit);
    end
  end
endmodule : dbw_watchdog
`default_nettype wire

// ==== sim/dbw_props.sv ====
// Port checker for the double-buffered output controller.
`timescale 1ns/100ps
`default_nettype none
module dbw_props #(
  parameter int CHANNELS = 8,
  parameter logic [9:0] BASE = 10'h390
) (
  input wire logic mclk,
  input wire logic srst,
  input wire dbw_pkg::dbw_io_s io,
  input wire logic clear_n,
  input wire logic [dbw_pkg::MAX_CH/2-1:0] bipolar_sel,
  input wire logic wd_enable,
  input wire logic [1:0] wd_sel,
  input wire logic [CHANNELS*dbw_pkg::CODE_W-1:0] out_codes,
  input wire logic latch_strobe,
  input wire logic wd_clear
);
  import dbw_pkg::*;
  logic [CHANNELS*CODE_W-1:0] zero_v;
  logic rd_base;
  assign rd_base = io.rd && io.addr == BASE;
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
      zero_v[c*CODE_W+:CODE_W] = bipolar_sel[c/2] ? ZERO_BIPOLAR : ZERO_UNIPOLAR;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_clr_held;
    !clear_n [*5];
  endsequence
  property p_strobe_pulse;
    latch_strobe |=> !latch_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_strobe_cause;
    latch_strobe |-> $past(rd_base, 3) || $past(rd_base, 4) || $past(rd_base, 5);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe uncaused");
  property p_rd_strobe;
    $rose(rd_base) && clear_n |-> ##[3:5] latch_strobe;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("no strobe");
  property p_only_strobe;
    $changed(out_codes) && clear_n && !wd_clear && !$past(wd_clear) |-> latch_strobe;
  endproperty
  a_only_strobe: assert property (p_only_strobe) else $error("codes moved");
  property p_clear_zero;
    s_clr_held |-> out_codes == zero_v;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear value");
  property p_clear_no_strobe;
    s_clr_held |-> !latch_strobe;
  endproperty
  a_clear_no_strobe: assert property (p_clear_no_strobe) else $error("strobe in clear");
  property p_reset_zero;
    $fell(srst) |-> out_codes == zero_v;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value");
  property p_wd_off;
    !wd_enable [*5] |-> !wd_clear;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog off fired");
  property p_wd_zero;
    wd_clear |=> !wd_clear ##[0:1] out_codes == zero_v;
  endproperty
  a_wd_zero: assert property (p_wd_zero) else $error("watchdog clear");
endmodule // dbw_props
bind dbw_ctrl dbw_props #(.CHANNELS(CHANNELS), .BASE(BASE)) u_props (.mclk(mclk), .srst(srst),
  .io(io), .clear_n(clear_n), .bipolar_sel(bipolar_sel), .wd_enable(wd_enable),
  .wd_sel(wd_sel), .out_codes(out_codes), .latch_strobe(latch_strobe), .wd_clear(wd_clear));
`default_nettype wire

// ==== sim/dbw_host.sv ====
// Host processor model issuing I/O cycles to the board.
`timescale 1ns/100ps
`default_nettype none
module dbw_host #(
  parameter logic [9:0] BASE = 10'h390
) (
  input wire logic mclk,
  output var dbw_pkg::dbw_io_s io
);
  import dbw_pkg::*;
  initial io = '0;
  // Released lines show inverted values so a stale address is never mistaken for a live one.
  task automatic cyc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    io <= '{wr: w, rd: !w, addr: a, data: d};
    repeat (4) @(posedge mclk);
    io <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    repeat (4) @(posedge mclk);
  endtask
  task automatic put(input int ch, input logic [11:0] v, input bit hi_first);
    logic [9:0] a;
    a = BASE + 10'(2 * ch);
    cyc(1'b1, a + 10'(hi_first), hi_first ? {4'h0, v[11:8]} : v[7:0]);
    cyc(1'b1, a + 10'(!hi_first), hi_first ? v[7:0] : {4'h0, v[11:8]});
  endtask
endmodule // dbw_host
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the double-buffered output controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dbw_pkg::*;
  localparam logic [9:0] BASE = 10'h390;
  localparam int WD_T0 = 200;
  localparam int WD_T1 = 400;
  localparam int WD_T2 = 600;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic clear_n = 1'b1;
  logic [3:0] bipolar_sel = 4'hA;
  logic wd_enable = 1'b0;
  logic [1:0] wd_sel = 2'h0;
  logic latch_strobe, wd_clear;
  logic [95:0] out_codes, zero_v, exp_v;
  dbw_io_s io;
  int n_fail = 0;
  int compares = 0;
  int n_strobe = 0;
  dbw_host #(.BASE(BASE)) u_host (.mclk(mclk), .io(io));
  dbw_ctrl #(.CHANNELS(8), .BASE(BASE), .SHORT_CYC(WD_T0), .MID_CYC(WD_T1),
    .LONG_CYC(WD_T2)) u_dut (
    .mclk(mclk), .srst(srst), .io(io), .clear_n(clear_n), .bipolar_sel(bipolar_sel),
    .wd_enable(wd_enable), .wd_sel(wd_sel), .out_codes(out_codes),
    .latch_strobe(latch_strobe), .wd_clear(wd_clear));
  initial forever #12.5 mclk = ~mclk;
  always @(negedge mclk) if (latch_strobe === 1'b1) n_strobe++;
  task automatic chk_v(input logic [95:0] g, input logic [95:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %0t codes %h", $time, g);
    end
  endtask
  task automatic chk_b(input logic g);
    compares++;
    if (g !== 1'b1)
    begin
      n_fail++;
      $display("mismatch %0t flag", $time);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_load;
    int s;
    s = n_strobe;
    u_host.put(0, 12'h234, 1'b0);
    u_host.put(1, 12'hABC, 1'b1);
    u_host.put(7, 12'hFFF, 1'b0);
    u_host.cyc(1'b1, BASE + 10'd16, 8'h55);
    u_host.cyc(1'b0, BASE + 10'd1, 8'h00);
    chk_v(out_codes, zero_v);
    u_host.cyc(1'b0, BASE, 8'h00);
    exp_v = {12'hFFF, zero_v[83:24], 24'hABC234};
    chk_v(out_codes, exp_v);
    chk_b(n_strobe == s + 1);
  endtask
  task automatic t_clear;
    int s;
    s = n_strobe;
    @(posedge mclk) clear_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk_v(out_codes, zero_v);
    u_host.cyc(1'b0, BASE, 8'h00);
    clear_n <= 1'b1;
    u_host.cyc(1'b0, BASE, 8'h00);
    chk_v(out_codes, zero_v);
    chk_b(n_strobe == s + 1);
  endtask
  task automatic t_wd;
    int n;
    int lim;
    for (int i = 0; i < 3; i++)
    begin
      lim = (i == 0) ? WD_T0 : (i == 1) ? WD_T1 : WD_T2;
      @(posedge mclk) wd_sel <= 2'(i);
      wd_enable <= 1'b1;
      repeat (100) @(posedge mclk);
      u_host.put(3, 12'h0F0, 1'b0);
      u_host.cyc(1'b0, BASE, 8'h00);
      chk_v(out_codes, {zero_v[95:48], 12'h0F0, zero_v[35:0]});
      n = 0;
      while (wd_clear !== 1'b1 && n < 2000)
      begin
        // Looked at away from the rising edge that launches the pulse.
        @(negedge mclk);
        n++;
      end
      chk_b(n >= lim - 20 && n <= lim - 8);
      @(posedge mclk) wd_enable <= 1'b0;
      repeat (3) @(posedge mclk);
      chk_v(out_codes, zero_v);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    finish_test;
  end
  initial
  begin
    for (int c = 0; c < 8; c++)
      zero_v[c*12+:12] = bipolar_sel[c/2] ? ZERO_BIPOLAR : ZERO_UNIPOLAR;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_v(out_codes, zero_v);
    t_load;
    t_clear;
    t_wd;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
